// File: design/tpwm_top.sv
/*
  tpwm_top: timer counter with normal and fast pwm modes, apb registers,
  compare output stage and pin pair override.
  assumes: pclk is the timer clock; apb master obeys apb protocol.
*/
// The register addresses and the APB register port were decided locally.
`timescale 1ns/100ps
module tpwm_top
  import tpwm_pkg::*;
#(
  parameter int unsigned CNT_W = TPWM_CNT_W
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [1:0] pin_val,
  output logic [1:0] pin_oe
);

  ////////////////////////////////////////////////////////////////////////
  // register state

  logic [1:0] com_q, com_d;
  logic pwm_q, pwm_d;
  logic slope_q, slope_d;
  logic run_q, run_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] cmp_q, cmp_d;
  logic [CNT_W-1:0] cmp_buf_q, cmp_buf_d;
  logic [CNT_W-1:0] top_q, top_d;
  logic [CNT_W-1:0] top_buf_q, top_buf_d;
  logic ovf_q, ovf_d;
  logic cmf_q, cmf_d;
  logic blk_q, blk_d;
  logic force_q, force_d;
  logic [1:0] pval_q, pval_d;
  logic [1:0] pdir_q, pdir_d;
  logic oc_q, oc_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [1:0] pin_val_q;
  logic [1:0] pin_oe_q;

  logic wave;
  logic match;
  logic at_top;
  logic bottom;
  logic wr_en;
  logic rd_en;
  logic cnt_wr;
  logic mapped;
  logic [1:0] pin_val_c;
  logic [1:0] pin_oe_c;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == TPWM_CTRL_OFS) || (a == TPWM_CNT_OFS) || (a == TPWM_CMP_OFS)
      || (a == TPWM_TOP_OFS) || (a == TPWM_STAT_OFS) || (a == TPWM_PORT_OFS);
  endfunction : is_mapped

  // write lands at the edge where pready is sampled high
  assign wr_en = psel && penable && pwrite && pready_q;
  assign rd_en = psel && penable && !pwrite && !pready_q;
  assign mapped = is_mapped(paddr);
  assign cnt_wr = wr_en && paddr == TPWM_CNT_OFS;

  ////////////////////////////////////////////////////////////////////////
  // counter events

  // run, top and count writes steer count; slope only gates bottom, pwm gates bottom and the compare and top reloads
  assign at_top = (cnt_q == top_q);
  assign match = run_q && !blk_q && (cnt_q == cmp_q);
  assign bottom = run_q && at_top && pwm_q && !slope_q;

  always_comb begin
    cnt_d = cnt_q;
    ovf_d = ovf_q;
    cmf_d = cmf_q;
    cmp_d = cmp_q;
    top_d = top_q;
    blk_d = cnt_wr;
    if (run_q) begin
      if (at_top) begin
        cnt_d = '0;
        ovf_d = 1'b1;
        if (pwm_q) begin
          cmp_d = cmp_buf_q;
          top_d = top_buf_q;
        end
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
    if (match) begin
      cmf_d = 1'b1;
    end
    if (!pwm_q) begin
      cmp_d = cmp_buf_q;
      top_d = top_buf_q;
    end
    if (cnt_wr) begin
      cnt_d = pwdata[CNT_W-1:0];
    end
    // clear by write one, set wins
    if (wr_en && paddr == TPWM_STAT_OFS) begin
      if (pwdata[TPWM_STAT_OVF_BIT] && !(run_q && at_top)) begin
        ovf_d = 1'b0;
      end
      if (pwdata[TPWM_STAT_CMF_BIT] && !match) begin
        cmf_d = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb register writes and reads

  always_comb begin
    com_d = com_q;
    pwm_d = pwm_q;
    slope_d = slope_q;
    run_d = run_q;
    cmp_buf_d = cmp_buf_q;
    top_buf_d = top_buf_q;
    pval_d = pval_q;
    pdir_d = pdir_q;
    force_d = 1'b0;
    prdata_d = prdata_q;
    pready_d = psel && penable && !pready_q;
    pslverr_d = psel && penable && !pready_q && !mapped;
    if (wr_en) begin
      if (paddr == TPWM_CTRL_OFS) begin
        // mode latched, used from the next clock by wave and pins
        com_d = pwdata[TPWM_CTRL_COM_LSB +: 2];
        pwm_d = pwdata[TPWM_CTRL_PWM_BIT];
        slope_d = pwdata[TPWM_CTRL_SLOPE_BIT];
        run_d = pwdata[TPWM_CTRL_RUN_BIT];
        force_d = pwdata[TPWM_CTRL_FORCE_BIT] && !pwdata[TPWM_CTRL_PWM_BIT];
      end else if (paddr == TPWM_CMP_OFS) begin
        cmp_buf_d = pwdata[CNT_W-1:0];
      end else if (paddr == TPWM_TOP_OFS) begin
        top_buf_d = pwdata[CNT_W-1:0];
      end else if (paddr == TPWM_PORT_OFS) begin
        pval_d = pwdata[TPWM_PORT_VAL_LSB +: 2];
        pdir_d = pwdata[TPWM_PORT_DIR_LSB +: 2];
      end
    end
    if (rd_en) begin
      prdata_d = '0;
      if (paddr == TPWM_CTRL_OFS) begin
        prdata_d[TPWM_CTRL_COM_LSB +: 2] = com_q;
        prdata_d[TPWM_CTRL_PWM_BIT] = pwm_q;
        prdata_d[TPWM_CTRL_SLOPE_BIT] = slope_q;
        prdata_d[TPWM_CTRL_RUN_BIT] = run_q;
      end else if (paddr == TPWM_CNT_OFS) begin
        prdata_d[CNT_W-1:0] = cnt_q;
      end else if (paddr == TPWM_CMP_OFS) begin
        prdata_d[CNT_W-1:0] = cmp_buf_q;
      end else if (paddr == TPWM_TOP_OFS) begin
        prdata_d[CNT_W-1:0] = top_buf_q;
      end else if (paddr == TPWM_STAT_OFS) begin
        prdata_d[TPWM_STAT_OVF_BIT] = ovf_q;
        prdata_d[TPWM_STAT_CMF_BIT] = cmf_q;
        prdata_d[TPWM_STAT_WAVE_BIT] = oc_q;
      end else if (paddr == TPWM_PORT_OFS) begin
        prdata_d[TPWM_PORT_VAL_LSB +: 2] = pval_q;
        prdata_d[TPWM_PORT_DIR_LSB +: 2] = pdir_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // waveform, output stage, pins

  tpwm_wave u_wave (
    .pclk(pclk),
    .presetn(presetn),
    .compare_output_mode(com_q),
    .pwm_enable_bit(pwm_q),
    .match(match),
    .bottom(bottom),
    .force_compare_strobe(force_q),
    .waveform_output(wave)
  );

  assign oc_d = wave;

  tpwm_pins u_pins (
    .compare_output_mode(com_q),
    .pwm_enable_bit(pwm_q),
    .cmp_true(oc_q),
    .cmp_inv(~oc_q),
    .port_val(pval_q),
    .port_dir(pdir_q),
    .pin_val(pin_val_c),
    .pin_oe(pin_oe_c)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      com_q <= TPWM_COM_OFF;
      pwm_q <= 1'b0;
      slope_q <= 1'b0;
      run_q <= 1'b0;
      cnt_q <= TPWM_CNT_RST;
      cmp_q <= TPWM_CMP_RST;
      cmp_buf_q <= TPWM_CMP_RST;
      top_q <= TPWM_TOP_RST;
      top_buf_q <= TPWM_TOP_RST;
      ovf_q <= 1'b0;
      cmf_q <= 1'b0;
      blk_q <= 1'b0;
      force_q <= 1'b0;
      pval_q <= 2'h0;
      pdir_q <= 2'h0;
      oc_q <= 1'b0;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      pin_val_q <= 2'h0;
      pin_oe_q <= 2'h0;
    end else begin
      com_q <= com_d;
      pwm_q <= pwm_d;
      slope_q <= slope_d;
      run_q <= run_d;
      cnt_q <= cnt_d;
      cmp_q <= cmp_d;
      cmp_buf_q <= cmp_buf_d;
      top_q <= top_d;
      top_buf_q <= top_buf_d;
      ovf_q <= ovf_d;
      cmf_q <= cmf_d;
      blk_q <= blk_d;
      force_q <= force_d;
      pval_q <= pval_d;
      pdir_q <= pdir_d;
      oc_q <= oc_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      pin_val_q <= pin_val_c;
      pin_oe_q <= pin_oe_c;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pin_val = pin_val_q;
  assign pin_oe = pin_oe_q;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_top_hit;
    run_q && at_top && !cnt_wr;
  endsequence

  property p_wrap;
    @(posedge pclk) disable iff (!presetn) s_top_hit |=> (cnt_q == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap after top");

  property p_ovf;
    @(posedge pclk) disable iff (!presetn) s_top_hit |=> ovf_q;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag not set at wrap");

  property p_count;
    @(posedge pclk) disable iff (!presetn)
      (run_q && !at_top && !cnt_wr) |=> (cnt_q == $past(cnt_q) + 1'b1);
  endproperty
  a_count: assert property (p_count) else $error("count did not step by one");

  property p_block;
    @(posedge pclk) disable iff (!presetn) cnt_wr |=> !match;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked after count write");

  property p_cnt_wr;
    @(posedge pclk) disable iff (!presetn)
      cnt_wr |=> (cnt_q == $past(pwdata[CNT_W-1:0]));
  endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("count write lost");

  property p_sync;
    @(posedge pclk) disable iff (!presetn) ##1 (oc_q == $past(wave));
  endproperty
  a_sync: assert property (p_sync) else $error("compare output not one clock behind");

  property p_off;
    @(posedge pclk) disable iff (!presetn)
      (com_q == TPWM_COM_OFF && !force_q) |=> (wave == $past(wave));
  endproperty
  a_off: assert property (p_off) else $error("output moved with mode zero");

  property p_tog;
    @(posedge pclk) disable iff (!presetn)
      (!pwm_q && com_q == TPWM_COM_TOG && match) |=> (wave != $past(wave));
  endproperty
  a_tog: assert property (p_tog) else $error("toggle mode did not invert");

  property p_nopin;
    @(posedge pclk) disable iff (!presetn)
      (com_q == TPWM_COM_OFF) |=> (pin_val_q == $past(pval_q));
  endproperty
  a_nopin: assert property (p_nopin) else $error("port value not on pins");

endmodule : tpwm_top

// File: design/tpwm_pkg.sv
/*
  tpwm_pkg: register offsets, field positions, reset values and mode
  encodings for the timer pwm mode logic.
  assumes: apb slave with 32-bit data, one aligned word per register.
*/
package tpwm_pkg;

  localparam int unsigned TPWM_CNT_W = 8;

  // register byte offsets
  localparam logic [7:0] TPWM_CTRL_OFS = 8'h00;
  localparam logic [7:0] TPWM_CNT_OFS = 8'h04;
  localparam logic [7:0] TPWM_CMP_OFS = 8'h08;
  localparam logic [7:0] TPWM_TOP_OFS = 8'h0C;
  localparam logic [7:0] TPWM_STAT_OFS = 8'h10;
  localparam logic [7:0] TPWM_PORT_OFS = 8'h14;

  // control field positions
  localparam int unsigned TPWM_CTRL_COM_LSB = 0;
  localparam int unsigned TPWM_CTRL_PWM_BIT = 2;
  localparam int unsigned TPWM_CTRL_SLOPE_BIT = 3;
  localparam int unsigned TPWM_CTRL_RUN_BIT = 4;
  localparam int unsigned TPWM_CTRL_FORCE_BIT = 5;

  // status field positions
  localparam int unsigned TPWM_STAT_OVF_BIT = 0;
  localparam int unsigned TPWM_STAT_CMF_BIT = 1;
  localparam int unsigned TPWM_STAT_WAVE_BIT = 2;

  // port register fields: value pair then direction pair
  localparam int unsigned TPWM_PORT_VAL_LSB = 0;
  localparam int unsigned TPWM_PORT_DIR_LSB = 2;

  // reset values
  localparam logic [7:0] TPWM_TOP_RST = 8'hFF;
  localparam logic [7:0] TPWM_CMP_RST = 8'h00;
  localparam logic [7:0] TPWM_CNT_RST = 8'h00;

  // compare output mode encodings
  localparam logic [1:0] TPWM_COM_OFF = 2'h0;
  localparam logic [1:0] TPWM_COM_TOG = 2'h1;
  localparam logic [1:0] TPWM_COM_CLR = 2'h2;
  localparam logic [1:0] TPWM_COM_SET = 2'h3;

  // pin drive select
  typedef enum logic [1:0] {
    TPWM_PIN_NONE,
    TPWM_PIN_SECOND,
    TPWM_PIN_BOTH
  } tpwm_pin_e;

endpackage : tpwm_pkg

// File: design/tpwm_wave.sv
/*
  tpwm_wave: waveform output from compare mode, counter events and force.
  assumes: match and bottom pulses come from the counter in the same clock.
*/
`timescale 1ns/100ps
module tpwm_wave
  import tpwm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] compare_output_mode,
  input wire logic pwm_enable_bit,
  input wire logic match,
  input wire logic bottom,
  input wire logic force_compare_strobe,
  output logic waveform_output
);

  logic wave_q;
  logic wave_d;

  function automatic logic nonpwm_act(input logic [1:0] mode, input logic cur);
    case (mode)
      TPWM_COM_TOG: nonpwm_act = ~cur;
      TPWM_COM_CLR: nonpwm_act = 1'b0;
      TPWM_COM_SET: nonpwm_act = 1'b1;
      default: nonpwm_act = cur;
    endcase
  endfunction : nonpwm_act

  always_comb begin
    wave_d = wave_q;
    if (!pwm_enable_bit) begin
      if (match || force_compare_strobe) begin
        wave_d = nonpwm_act(compare_output_mode, wave_q);
      end
    end else begin
      if (compare_output_mode == TPWM_COM_SET) begin
        if (match) begin
          wave_d = 1'b1;
        end else if (bottom) begin
          wave_d = 1'b0;
        end
      end else if (compare_output_mode != TPWM_COM_OFF) begin
        if (match) begin
          wave_d = 1'b0;
        end else if (bottom) begin
          wave_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_q <= 1'b0;
    end else begin
      wave_q <= wave_d;
    end
  end

  assign waveform_output = wave_q;

endmodule : tpwm_wave

// File: design/tpwm_pins.sv
/*
  tpwm_pins: pin pair source select between compare outputs and port.
  assumes: compare outputs already delayed one clock behind the waveform.
*/
`timescale 1ns/100ps
module tpwm_pins
  import tpwm_pkg::*;
(
  input wire logic [1:0] compare_output_mode,
  input wire logic pwm_enable_bit,
  input wire logic cmp_true,
  input wire logic cmp_inv,
  input wire logic [1:0] port_val,
  input wire logic [1:0] port_dir,
  output logic [1:0] pin_val,
  output logic [1:0] pin_oe
);

  tpwm_pin_e sel;

  always_comb begin
    if (compare_output_mode == TPWM_COM_OFF) begin
      sel = TPWM_PIN_NONE;
    end else if (pwm_enable_bit && compare_output_mode == TPWM_COM_TOG) begin
      sel = TPWM_PIN_BOTH;
    end else begin
      sel = TPWM_PIN_SECOND;
    end
    pin_val = port_val;
    if (sel != TPWM_PIN_NONE && (&port_dir)) begin
      pin_val[1] = cmp_true;
      if (sel == TPWM_PIN_BOTH) begin
        pin_val[0] = cmp_inv;
      end
    end
    pin_oe = port_dir;
  end

endmodule : tpwm_pins

// File: verification/tpwm_switch_model.sv
/*
  tpwm_switch_model: gate inputs of the external switch pair on the pins.
  assumes: each gate input has a pull-down while the pin is not driven.
*/
`timescale 1ns/100ps
module tpwm_switch_model (
  input wire logic [1:0] pin_val,
  input wire logic [1:0] pin_oe,
  output logic [1:0] pad
);
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pad[i] = pin_oe[i] ? pin_val[i] : 1'b0;
    end
  end
endmodule : tpwm_switch_model

// File: verification/tpwm_top_bench.sv
/*
  tpwm_top_bench: self-checking bench for the timer pwm block over apb.
  assumes: tpwm_pkg layout; switch model on the pin pair.
*/
`timescale 1ns/100ps
module tpwm_top_bench;
  import tpwm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] pin_val, pin_oe, pad;
  int miscompares, check_count, per, hi, top, cmp;
  logic [7:0] ofs [6];
  logic [31:0] rst_v [6];
  logic [1:0] fmode [5];
  logic fexp [5];

  tpwm_top #(.CNT_W(TPWM_CNT_W)) i_tpwm_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_val(pin_val), .pin_oe(pin_oe));
  tpwm_switch_model i_tpwm_switch_model (.pin_val(pin_val), .pin_oe(pin_oe), .pad(pad));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50) begin
      miscompares++;
      end_of_test();
    end
  endtask : apb

  task automatic wait_lvl(input logic v);
    int n;
    n = 0;
    while (pad[1] !== v && n < 600) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 600) begin
      miscompares++;
      end_of_test();
    end
  endtask : wait_lvl

  // period and high time of the true pin, in clocks
  task automatic meas();
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    per = 0;
    hi = 0;
    do begin
      if (pad[1] === 1'b1) hi++;
      per++;
      @(posedge pclk);
    end while (!(pad[1] === 1'b1 && hi < per) && per < 600);
    if (per >= 600) begin
      miscompares++;
      end_of_test();
    end
  endtask : meas

  function automatic logic [31:0] ctrl(input logic [1:0] m, input logic pwm, input logic run);
    return {26'h0, 1'b0, run, 1'b0, pwm, m};
  endfunction : ctrl

  ////////////////////////////////////////////////////////////////////////
  initial begin
    miscompares = 0;
    check_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ofs = '{TPWM_CTRL_OFS, TPWM_CNT_OFS, TPWM_CMP_OFS, TPWM_TOP_OFS, TPWM_STAT_OFS,
      TPWM_PORT_OFS};
    rst_v = '{32'h0, 32'h0, 32'h0, 32'hFF, 32'h0, 32'h0};
    fmode = '{TPWM_COM_SET, TPWM_COM_OFF, TPWM_COM_CLR, TPWM_COM_TOG, TPWM_COM_TOG};
    fexp = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    void'($urandom(32'h8f04));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk("reset value", rd, rst_v[i]);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", {31'h0, er}, 32'h1);
    apb(1'b1, TPWM_CNT_OFS, 32'h5);
    apb(1'b0, TPWM_CNT_OFS, 32'h0);
    chk("count", rd, 32'h5);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, TPWM_CTRL_OFS, ctrl(fmode[i], 1'b0, 1'b0));
      apb(1'b1, TPWM_CTRL_OFS, ctrl(fmode[i], 1'b0, 1'b0) | 32'h20);
      apb(1'b0, TPWM_STAT_OFS, 32'h0);
      chk("forced wave", {31'h0, rd[TPWM_STAT_WAVE_BIT]}, {31'h0, fexp[i]});
      chk("force flags", {30'h0, rd[1:0]}, 32'h0);
    end
    apb(1'b0, TPWM_CNT_OFS, 32'h0);
    chk("count after force", rd, 32'h5);
    for (int i = 0; i < 4; i++) begin
      top = $urandom_range(3, 0);
      apb(1'b1, TPWM_CTRL_OFS, ctrl(i[1:0], 1'b0, 1'b0));
      apb(1'b1, TPWM_PORT_OFS, {28'h0, 2'b10, top[1:0]});
      repeat (3) @(posedge pclk);
      chk("pin oe", {30'h0, pin_oe}, 32'h2);
      chk("pin port value", {31'h0, pin_val[1]}, {31'h0, top[1]});
    end
    apb(1'b1, TPWM_PORT_OFS, 32'hF);
    for (int i = 0; i < 3; i++) begin
      top = $urandom_range(6, 0);
      apb(1'b1, TPWM_TOP_OFS, top);
      apb(1'b1, TPWM_CMP_OFS, 32'h0);
      apb(1'b1, TPWM_CTRL_OFS, ctrl(TPWM_COM_TOG, 1'b0, 1'b1));
      meas();
      meas();
      chk("toggle period", per, 2 * (top + 1));
      chk("toggle high", hi, top + 1);
      chk("first pin port value", {31'h0, pad[0]}, 32'h1);
    end
    apb(1'b0, TPWM_STAT_OFS, 32'h0);
    chk("overflow", {31'h0, rd[TPWM_STAT_OVF_BIT]}, 32'h1);
    apb(1'b1, TPWM_CTRL_OFS, 32'h0);
    apb(1'b1, TPWM_STAT_OFS, 32'h3);
    apb(1'b0, TPWM_STAT_OFS, 32'h0);
    chk("overflow clear", {31'h0, rd[TPWM_STAT_OVF_BIT]}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      top = $urandom_range(8, 2);
      cmp = $urandom_range(top - 1, 0);
      apb(1'b1, TPWM_TOP_OFS, top);
      apb(1'b1, TPWM_CMP_OFS, cmp);
      apb(1'b0, TPWM_CMP_OFS, 32'h0);
      chk("compare readback", rd, cmp);
      apb(1'b1, TPWM_CTRL_OFS, ctrl(2'(i % 3 + 1), 1'b1, 1'b1));
      meas();
      meas();
      chk("pwm period", per, top + 1);
      chk("pwm high", hi, (i % 3 == 2) ? top - cmp : cmp + 1);
      chk("pin pair", {30'h0, pad}, (i % 3 == 0) ? 32'h2 : 32'h3);
      apb(1'b0, TPWM_STAT_OFS, 32'h0);
      chk("pwm overflow", {31'h0, rd[TPWM_STAT_OVF_BIT]}, 32'h1);
      apb(1'b1, TPWM_STAT_OFS, 32'h1);
    end
    // slope bit set: no bottom edge
    apb(1'b1, TPWM_CTRL_OFS, 32'h1E);
    repeat (40) @(posedge pclk);
    apb(1'b0, TPWM_STAT_OFS, 32'h0);
    chk("slope wave", {31'h0, rd[TPWM_STAT_WAVE_BIT]}, 32'h0);
    end_of_test();
  end
endmodule : tpwm_top_bench
